// ==== core/pmos_sequencer.sv ====
// pmos_sequencer: chooses what the shared differential output shows per step
// assumes strobe, enable pin and comparator results are synchronous to clk
// Contract
// - each device pass: bv/shunt for channels 1-4, aux1, aux2, reference ground.
// - step zero selects nothing; output stays high impedance.
// - paired: first device drives its pass, then second; slots never overlap.
// - alternating: reversed passes follow in turn, then wrap to channel 1 bus voltage.
// - bus valid held low until all used bus inputs exceed threshold.
// - only channels enabled in the channel mask count for bus valid.
// - skip low releases bus valid always; skip high in standby drives it low.
// - without supply and skip high, bus valid held low.
// - timeout on: strobe held over 45 us returns to step zero.
// - enable pin toggle resets sequence to step zero.
// - enable floating: sequence in reset, output hi-z; standby: sequence in reset, output hi-z, bus valid pulled low with skip high.
`timescale 1ns/10ps
`default_nettype none
module pmos_sequencer (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // configuration register port
  input  wire pmos_pkg::pmos_cfg_wr_t cfgWr,
  input  wire logic [7:0]            cfgRdAddr,
  output logic [7:0]                 cfgRdData,
  // pins
  input  wire logic                  stepStrobe,
  input  wire pmos_pkg::pmos_en_t    enableLevel,
  input  wire logic                  supplyGood,
  input  wire logic                  skipPin,
  input  wire logic [3:0]            busAboveRef,
  // differential output, bus valid and step count
  output pmos_pkg::pmos_out_t        diffOut,
  output logic                       busValidOut,
  output logic                       busValidOe,
  output logic [5:0]                 stepCount
);
  import pmos_pkg::*;

  // ----------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------
  logic [7:0] chanEn_q, chanEn_d;
  logic [7:0] pairing_q, pairing_d;
  logic [7:0] seqMode_q, seqMode_d;

  // writes land on the printed offsets; other addresses are ignored
  always_comb begin
    chanEn_d  = chanEn_q;
    pairing_d = pairing_q;
    seqMode_d = seqMode_q;
    if (cfgWr.wr) begin
      case (cfgWr.addr)
        PMOS_REG_CHAN_EN: chanEn_d  = cfgWr.data;
        PMOS_REG_PAIRING: pairing_d = cfgWr.data;
        PMOS_REG_SEQMODE: seqMode_d = cfgWr.data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      chanEn_q  <= PMOS_CHAN_EN_RST;
      pairing_q <= PMOS_PAIRING_RST;
      seqMode_q <= PMOS_SEQMODE_RST;
    end else begin
      chanEn_q  <= chanEn_d;
      pairing_q <= pairing_d;
      seqMode_q <= seqMode_d;
    end
  end

  // read back; unmapped offsets read zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfgRdData <= 8'h00;
    end else begin
      case (cfgRdAddr)
        PMOS_REG_CHAN_EN: cfgRdData <= chanEn_q;
        PMOS_REG_PAIRING: cfgRdData <= pairing_q;
        PMOS_REG_SEQMODE: cfgRdData <= seqMode_q;
        default:          cfgRdData <= 8'h00;
      endcase
    end
  end

  logic pairedMode, secondSlot, altMode, timeoutEn;
  assign pairedMode = pairing_q[PMOS_PAIR_EN_BIT];
  assign secondSlot = pairing_q[PMOS_PAIR_SECOND_BIT];
  assign altMode    = seqMode_q[PMOS_SEQ_ALT_BIT];
  assign timeoutEn  = !seqMode_q[PMOS_SEQ_TMO_DIS_BIT];

  // ----------------------------------------------------------
  // strobe edges and timeout
  // ----------------------------------------------------------
  logic strobeEdge, timeoutHit;

  pmos_strobe_timer u_timer (
    .clk        (clk),
    .reset      (reset),
    .stepStrobe (stepStrobe),
    .timeoutEn  (timeoutEn),
    .strobeEdge (strobeEdge),
    .timeoutHit (timeoutHit)
  );

  // ----------------------------------------------------------
  // step counter
  // ----------------------------------------------------------
  pmos_en_t   enPrev_q, enPrev_d;
  logic [5:0] step_q, step_d;
  logic [5:0] lastStep;
  logic       seqRun;

  // last step: 11 single, 22 paired, doubled again for the reversed pass
  always_comb begin
    lastStep = {2'b00, PMOS_PASS_LEN};
    if (pairedMode) begin
      lastStep = 6'({PMOS_PASS_LEN, 1'b0});
    end
    if (altMode) begin
      lastStep = 6'({lastStep, 1'b0});
    end
  end

  assign seqRun = (enableLevel == PMOS_EN_ACTIVE);

  always_comb begin
    enPrev_d = enableLevel;
    step_d   = step_q;
    if (!seqRun || enableLevel != enPrev_q) begin
      step_d = PMOS_STEP_ZERO;
    end else if (timeoutHit) begin
      step_d = PMOS_STEP_ZERO;
    end else if (strobeEdge) begin
      // every strobe counts, whoever owns the slot
      if (step_q >= lastStep) begin // also ends a run shortened mid-sequence
        step_d = 6'h01;
      end else begin
        step_d = step_q + 6'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      enPrev_q <= PMOS_EN_ACTIVE; // no false toggle on the first edge after reset
      step_q   <= PMOS_STEP_ZERO;
    end else begin
      enPrev_q <= enPrev_d;
      step_q   <= step_d;
    end
  end

  assign stepCount = step_q;

  // ----------------------------------------------------------
  // slot decode
  // ----------------------------------------------------------
  // split the step into pass number and position within the pass
  logic [5:0] rel;
  logic [2:0] passIdx;
  logic       ownPass;
  pmos_out_t  out_d;

  always_comb begin
    rel     = 6'h00;
    passIdx = 3'h0;
    out_d   = '{drive: 1'b0, reversed: 1'b0, sel: PMOS_SEL_NONE};
    if (step_q != PMOS_STEP_ZERO && seqRun) begin
      rel = step_q - 6'h01;
      while_pass: begin
        if (rel >= 6'({PMOS_PASS_LEN, 1'b0}) + 6'({2'b00, PMOS_PASS_LEN})) begin
          rel = rel - 6'({PMOS_PASS_LEN, 1'b0}) - 6'({2'b00, PMOS_PASS_LEN});
          passIdx = 3'h3;
        end else if (rel >= 6'({PMOS_PASS_LEN, 1'b0})) begin
          rel = rel - 6'({PMOS_PASS_LEN, 1'b0});
          passIdx = 3'h2;
        end else if (rel >= {2'b00, PMOS_PASS_LEN}) begin
          rel = rel - {2'b00, PMOS_PASS_LEN};
          passIdx = 3'h1;
        end
      end
      if (pairedMode) begin
        ownPass        = passIdx[0] == secondSlot;
        out_d.reversed = passIdx[1];
      end else begin
        ownPass        = 1'b1;
        out_d.reversed = passIdx[0];
      end
      out_d.drive = ownPass;
      out_d.sel   = ownPass ? pmos_sel_t'(rel[3:0]) : PMOS_SEL_NONE;
    end else begin
      ownPass = 1'b0;
    end
  end

  // output is registered; hi-z is shown by drive low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      diffOut <= '{drive: 1'b0, reversed: 1'b0, sel: PMOS_SEL_NONE};
    end else begin
      diffOut <= out_d;
    end
  end

  // ----------------------------------------------------------
  // bus valid flag
  // ----------------------------------------------------------
  // comparator keeps working in float mode; standby with skip high pulls low
  logic allValid, pullLow_d, pullLow_q;

  always_comb begin
    allValid  = &(busAboveRef | ~chanEn_q[PMOS_NUM_CHAN-1:0]);
    pullLow_d = 1'b0;
    if (skipPin) begin
      if (!supplyGood) begin
        pullLow_d = 1'b1;
      end else if (enableLevel == PMOS_EN_STANDBY) begin
        pullLow_d = 1'b1;
      end else begin
        pullLow_d = !allValid;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pullLow_q <= 1'b0;
    end else begin
      pullLow_q <= pullLow_d;
    end
  end

  // open drain: only ever drives zero
  assign busValidOut = 1'b0;
  assign busValidOe  = pullLow_q;

endmodule
`default_nettype wire

// ==== core/pmos_pkg.sv ====
// pmos_pkg: shared constants and types for the paired monitor output sequencer
// assumes a single 200 MHz clock domain; analog quantities arrive as digital levels
`default_nettype none
package pmos_pkg;

  // ------------------------------------------------------------
  // register map (printed offsets, reached over the config port)
  // ------------------------------------------------------------
  localparam logic [7:0] PMOS_REG_CHAN_EN = 8'h04;
  localparam logic [7:0] PMOS_REG_PAIRING = 8'h05;
  localparam logic [7:0] PMOS_REG_SEQMODE = 8'h06;
  localparam logic [7:0] PMOS_CHAN_EN_RST = 8'hbf;
  localparam logic [7:0] PMOS_PAIRING_RST = 8'h00;
  localparam logic [7:0] PMOS_SEQMODE_RST = 8'h00;

  // field positions
  localparam int PMOS_SEQ_ALT_BIT     = 7;   // alternating reversed pass
  localparam int PMOS_SEQ_TMO_DIS_BIT = 6;   // timeout disable
  localparam int PMOS_PAIR_EN_BIT     = 0;   // paired operation on
  localparam int PMOS_PAIR_SECOND_BIT = 4;   // this device owns second slot

  // ------------------------------------------------------------
  // sequence geometry
  // ------------------------------------------------------------
  localparam int         PMOS_NUM_CHAN  = 4;
  localparam logic [3:0] PMOS_PASS_LEN  = 4'hb;   // steps per device pass
  localparam logic [5:0] PMOS_STEP_ZERO = 6'h00;
  localparam logic [5:0] PMOS_STEP_MAX  = 6'h2c;  // last step of a full alternating run

  // ------------------------------------------------------------
  // strobe timeout
  // ------------------------------------------------------------
  localparam int CLK_MHZ          = 200;
  localparam int STROBE_TMO_US    = 45;
  localparam int STROBE_TMO_CYC   = STROBE_TMO_US * CLK_MHZ;  // longest time rounds down

  // output selection codes
  typedef enum logic [3:0] {
    PMOS_SEL_BV1 = 4'h0, PMOS_SEL_SC1 = 4'h1, PMOS_SEL_BV2 = 4'h2, PMOS_SEL_SC2 = 4'h3,
    PMOS_SEL_BV3 = 4'h4, PMOS_SEL_SC3 = 4'h5, PMOS_SEL_BV4 = 4'h6, PMOS_SEL_SC4 = 4'h7,
    PMOS_SEL_AUX1 = 4'h8, PMOS_SEL_AUX2 = 4'h9, PMOS_SEL_RGND = 4'ha, PMOS_SEL_NONE = 4'hf
  } pmos_sel_t;

  // enable pin levels
  typedef enum logic [1:0] {
    PMOS_EN_ACTIVE  = 2'h0,
    PMOS_EN_FLOAT   = 2'h1,
    PMOS_EN_STANDBY = 2'h2
  } pmos_en_t;

  // what the differential output shows
  typedef struct packed {
    logic      drive;
    logic      reversed;
    pmos_sel_t sel;
  } pmos_out_t;

  // register write port
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } pmos_cfg_wr_t;

endpackage
`default_nettype wire

// ==== core/pmos_strobe_timer.sv ====
// pmos_strobe_timer: edge detect and level-hold timeout on the step strobe
// assumes the strobe is already synchronous to clk
`timescale 1ns/10ps
`default_nettype none
module pmos_strobe_timer (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // strobe and control
  input  wire logic stepStrobe,
  input  wire logic timeoutEn,
  // events
  output logic      strobeEdge,
  output logic      timeoutHit
);
  import pmos_pkg::*;

  logic        strobe_q,  strobe_d;
  logic [15:0] holdCnt_q, holdCnt_d;
  logic        fired_q,   fired_d;

  // ----------------------------------------------------------
  // hold counter
  // ----------------------------------------------------------
  // fires once per held level so a stuck strobe does not reset forever
  always_comb begin
    strobe_d   = stepStrobe;
    strobeEdge = stepStrobe ^ strobe_q;
    holdCnt_d  = holdCnt_q;
    fired_d    = fired_q;
    timeoutHit = 1'b0;
    if (strobeEdge) begin
      holdCnt_d = 16'h0000;
      fired_d   = 1'b0;
    end else if (!fired_q) begin
      if (holdCnt_q == 16'(STROBE_TMO_CYC - 1)) begin
        timeoutHit = timeoutEn;
        fired_d    = 1'b1;
      end else begin
        holdCnt_d = holdCnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      strobe_q  <= 1'b0;
      holdCnt_q <= 16'h0000;
      fired_q   <= 1'b0;
    end else begin
      strobe_q  <= strobe_d;
      holdCnt_q <= holdCnt_d;
      fired_q   <= fired_d;
    end
  end

endmodule
`default_nettype wire

// ==== dv/pmos_sequencer_props.sv ====
// pmos_sequencer_props: port-level checks on the output sequencer
// assumes it is bound onto pmos_sequencer, single clock domain
`timescale 1ns/10ps
`default_nettype none
module pmos_sequencer_props (
  // clock and reset
  input wire logic                   clk,
  input wire logic                   reset,
  // register port
  input wire pmos_pkg::pmos_cfg_wr_t cfgWr,
  input wire logic [7:0]             cfgRdAddr,
  input wire logic [7:0]             cfgRdData,
  // pins
  input wire logic                   stepStrobe,
  input wire pmos_pkg::pmos_en_t     enableLevel,
  input wire logic                   supplyGood,
  input wire logic                   skipPin,
  input wire logic [3:0]             busAboveRef,
  // outputs
  input wire pmos_pkg::pmos_out_t    diffOut,
  input wire logic                   busValidOut,
  input wire logic                   busValidOe,
  input wire logic [5:0]             stepCount
);
  import pmos_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // diffOut trails stepCount by one cycle, so idle is judged on the old step
  a_idle_out_hiz: assert property ($past(stepCount) == 6'h00 |-> !diffOut.drive)
    else $error("output driven at idle step");
  a_skip_releases: assert property (!skipPin |=> !busValidOe)
    else $error("bus valid pulled with skip low");
  a_standby_pulls: assert property (skipPin && enableLevel == PMOS_EN_STANDBY |=> busValidOe)
    else $error("bus valid released in standby");
  a_unpowered_pulls: assert property (skipPin && !supplyGood |=> busValidOe)
    else $error("bus valid released without supply");
  a_all_above: assert property (skipPin && supplyGood && enableLevel != PMOS_EN_STANDBY
    && busAboveRef == 4'hf |=> !busValidOe)
    else $error("bus valid held with all inputs above");
  a_seq_held: assert property (enableLevel != PMOS_EN_ACTIVE |=> stepCount == 6'h00)
    else $error("sequence runs while not enabled");
  a_float_hiz: assert property ((enableLevel != PMOS_EN_ACTIVE) [*2] |=> !diffOut.drive)
    else $error("output driven while not enabled");
  a_strobe_steps: assert property ($changed(stepStrobe) && enableLevel == PMOS_EN_ACTIVE
    && $stable(enableLevel) |=> stepCount != $past(stepCount))
    else $error("strobe change not counted");
  a_step_holds: assert property (!$changed(stepStrobe) |=> stepCount == $past(stepCount)
    || stepCount == 6'h00)
    else $error("step moved without strobe");
endmodule
`default_nettype wire

// ==== dv/pmos_strobe_ctrl.sv ====
// pmos_strobe_ctrl: controller model that drives the step strobe
// assumes stepReq is a one-cycle request from the bench
`timescale 1ns/10ps
`default_nettype none
module pmos_strobe_ctrl (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // request and strobe pin
  input  wire logic stepReq,
  output logic      stepStrobe
);
  logic strobe_q;
  logic strobe_d;
  // one level change per request; holding the level is how a timeout is made
  always_comb strobe_d = stepReq ? ~strobe_q : strobe_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) strobe_q <= 1'b0;
    else strobe_q <= strobe_d;
  end
  assign stepStrobe = strobe_q;
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// tb: self-checking bench for the output sequencer
// assumes package, design and strobe controller model compiled first
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pmos_pkg::*;
  logic         clk = 1'b0;
  logic         reset = 1'b1;
  logic         stepReq = 1'b0;
  logic         supplyGood = 1'b1;
  logic         skipPin = 1'b0;
  logic         stepStrobe;
  pmos_cfg_wr_t cfgWr = '0;
  logic [7:0]   cfgRdAddr = 8'h00;
  logic [7:0]   cfgRdData;
  pmos_en_t     enableLevel = PMOS_EN_ACTIVE;
  logic [3:0]   busAboveRef = 4'h0;
  pmos_out_t    diffOut;
  logic         busValidOut;
  logic         busValidOe;
  logic [5:0]   stepCount;
  int           nMismatch = 0;
  int           checked = 0;
  always #2.5 clk = ~clk;
  pmos_strobe_ctrl u_ctrl (.clk, .reset, .stepReq, .stepStrobe);
  pmos_sequencer DUT (.clk, .reset, .cfgWr, .cfgRdAddr, .cfgRdData, .stepStrobe, .enableLevel,
    .supplyGood, .skipPin, .busAboveRef, .diffOut, .busValidOut, .busValidOe, .stepCount);
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, nMismatch);
    if (nMismatch == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      nMismatch++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // hi-z output folds to zero, since the select is meaningless then
  function automatic logic [7:0] view(input pmos_out_t d);
    return {2'b00, d.drive, d.drive ? {d.reversed, d.sel} : 5'h00};
  endfunction
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) cfgWr = '{1'b1, a, d};
    @(negedge clk) cfgWr.wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk) cfgRdAddr = a;
    @(negedge clk) cmp_byte(cfgRdData, e, "readback");
  endtask
  // one strobe change, then wait until diffOut has caught up
  task automatic step();
    @(negedge clk) stepReq = 1'b1;
    @(negedge clk) stepReq = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic sc_single();
    cmp_byte(view(diffOut), 8'h00, "idle output");
    for (int s = 1; s <= 12; s++) begin
      step();
      cmp_byte(view(diffOut), {4'h2, 4'((s - 1) % 11)}, "single pass");
    end
    cmp_byte({2'b00, stepCount}, 8'h01, "wrap");
  endtask
  task automatic sc_enable();
    @(negedge clk) enableLevel = PMOS_EN_FLOAT;
    step();
    cmp_byte({2'b00, stepCount}, 8'h00, "held step");
    cmp_byte(view(diffOut), 8'h00, "floating output");
    @(negedge clk) enableLevel = PMOS_EN_ACTIVE;
    step();
    cmp_byte(view(diffOut), 8'h20, "restart");
  endtask
  task automatic sc_busvalid();
    logic [8:0] tbl [8] = '{9'h000, 9'h101, 9'h1df, 9'h0c0, 9'h18a, 9'h189, 9'h1b5, 9'h1aa};
    wr_reg(PMOS_REG_CHAN_EN, 8'hb5);
    foreach (tbl[i]) begin
      @(negedge clk);
      {skipPin, supplyGood} = tbl[i][8:7];
      enableLevel = pmos_en_t'(tbl[i][6:5]);
      busAboveRef = tbl[i][4:1];
      repeat (2) @(negedge clk);
      cmp_byte({7'h00, busValidOe}, {7'h00, tbl[i][0]}, "bus valid");
      cmp_byte({7'h00, busValidOut}, 8'h00, "open drain data");
    end
    enableLevel = PMOS_EN_ACTIVE;
  endtask
  task automatic sc_paired();
    int p;
    wr_reg(PMOS_REG_PAIRING, 8'h11);
    wr_reg(PMOS_REG_SEQMODE, 8'h80);
    rd_chk(PMOS_REG_SEQMODE, 8'h80);
    for (int s = 1; s <= 45; s++) begin
      step();
      p = ((s - 1) / 11) % 4;
      cmp_byte({2'b00, stepCount}, 8'(s > 44 ? 1 : s), "shared count");
      cmp_byte(view(diffOut), p[0] ? {3'b001, p[1], 4'((s - 1) % 11)} : 8'h00, "slot");
    end
  endtask
  task automatic sc_timeout();
    int n;
    wr_reg(PMOS_REG_SEQMODE, 8'h00);
    step();
    n = 0;
    while (stepCount != 6'h00 && n < 9100) begin
      @(negedge clk);
      n++;
    end
    cmp_byte({7'h00, n > 8900 && n < 9100}, 8'h01, "timeout return");
    if (n >= 9100) give_verdict();
    wr_reg(PMOS_REG_SEQMODE, 8'h40);
    step();
    repeat (9100) @(negedge clk);
    cmp_byte({2'b00, stepCount}, 8'h01, "no timeout");
  endtask
  // first device of a pair: owns passes 0 and 2, the second of them reversed
  task automatic sc_first();
    int p;
    wr_reg(PMOS_REG_PAIRING, 8'h01);
    @(negedge clk) enableLevel = PMOS_EN_STANDBY;
    @(negedge clk) enableLevel = PMOS_EN_ACTIVE;
    @(negedge clk) cmp_byte({2'b00, stepCount}, 8'h00, "toggle restart");
    for (int s = 1; s <= 45; s++) begin
      step();
      p = ((s - 1) / 11) % 4;
      cmp_byte({2'b00, stepCount}, 8'(s > 44 ? 1 : s), "first count");
      cmp_byte(view(diffOut), p[0] ? 8'h00 : {3'b001, p[1], 4'((s - 1) % 11)}, "first slot");
    end
  endtask
  // single device with alternation: plain pass, then the same pass reversed
  task automatic sc_alone();
    wr_reg(PMOS_REG_PAIRING, 8'h00);
    @(negedge clk) enableLevel = PMOS_EN_FLOAT;
    @(negedge clk) enableLevel = PMOS_EN_ACTIVE;
    for (int s = 1; s <= 23; s++) begin
      step();
      cmp_byte({2'b00, stepCount}, 8'(s > 22 ? 1 : s), "alone count");
      cmp_byte(view(diffOut), {3'b001, 1'((s - 1) / 11), 4'((s - 1) % 11)}, "alone slot");
    end
  endtask
  // main sequence
  initial begin
    repeat (10) @(negedge clk);
    reset = 1'b0;
    rd_chk(PMOS_REG_CHAN_EN, 8'hbf);
    rd_chk(PMOS_REG_PAIRING, 8'h00);
    rd_chk(8'h07, 8'h00);
    sc_single();
    sc_enable();
    sc_busvalid();
    sc_paired();
    sc_first();
    sc_alone();
    sc_timeout();
    give_verdict();
  end
endmodule
bind pmos_sequencer pmos_sequencer_props u_props (.clk, .reset, .cfgWr, .cfgRdAddr, .cfgRdData,
  .stepStrobe, .enableLevel, .supplyGood, .skipPin, .busAboveRef, .diffOut, .busValidOut,
  .busValidOe, .stepCount);
`default_nettype wire
